// file: inc/sdmi_pkg.sv
package sdmi_pkg;
   // ==========================================
   // command encodings {cs_n, ras_n, cas_n, we_n}
   localparam logic [3:0] CMD_NOP = 4'h7;
   localparam logic [3:0] CMD_READ = 4'h5;
   localparam logic [3:0] CMD_WRITE = 4'h4;
   localparam logic [3:0] CMD_TERM = 4'h6;
   localparam logic [3:0] CMD_MODE_LOAD = 4'h0;
   // ==========================================
   // mode field positions
   localparam int MODE_W = 13;
   localparam int BURST_LSB = 0;
   localparam int ORDER_BIT = 3;
   localparam int LAT_LSB = 4;
   localparam int OPM_LOW = 7;
   localparam int OPM_HIGH = 8;
   localparam int WBURST_BIT = 9;
   // ==========================================
   // encodings
   localparam logic [2:0] BURST_1 = 3'h0;
   localparam logic [2:0] BURST_2 = 3'h1;
   localparam logic [2:0] BURST_4 = 3'h2;
   localparam logic [2:0] BURST_8 = 3'h3;
   localparam logic [2:0] BURST_PAGE = 3'h7;
   localparam logic [2:0] LAT_2 = 3'h2;
   localparam logic [2:0] LAT_3 = 3'h3;
   // power-up default (contents undefined in silicon; fixed here)
   localparam logic [12:0] MODE_RESET = 13'h0000;
   localparam int COL_W = 11;
   localparam logic [11:0] PAGE_X4 = 12'h800;
   localparam logic [11:0] PAGE_X8 = 12'h400;
   localparam logic [11:0] PAGE_X16 = 12'h200;
   typedef enum logic [1:0] {
      SDMI_IDLE = 2'h0,
      SDMI_BURST = 2'h1
   } sdmi_state_t;
endpackage

// file: rtl/sdmi_core.sv
`timescale 1ns/10ps
// Overview of operation
// - mode contents undefined at power-up; load before operating. Here reset loads MODE_RESET (13'h0000) instead.
// - mode load with both bank selects zero captures the address bus.
// - data outputs float after a mode load.
// - fields: burst size, order, latency, op mode, write burst.
// - bursts 1,2,4,8 either order; full page sequential only.
// - upper column bits pick the aligned block, burst wraps inside.
// - sequential adds modulo size; interleaved xors start with count.
// - full page wraps at page end; 2048, 1024 or 512 columns.
// - burst of one uses all column bits, order bit ignored.
// - read latency two or three cycles.
// - data driven from edge n+m-1, valid by n+m.
// - write burst bit one makes writes single-location; in full-page mode writes here still run until a terminate.
module sdmi_core
   import sdmi_pkg::*;
#(
   parameter int PAGE_COLS = 512
) (
   // clock and reset
   input wire logic clk,
   input wire logic resetn,
   // command bus
   input wire logic cke,
   input wire logic cs_n,
   input wire logic ras_n,
   input wire logic cas_n,
   input wire logic we_n,
   input wire logic bank_select_low,
   input wire logic bank_select_high,
   input wire logic [12:0] addr,
   // column sequencer outputs
   output logic [10:0] col_addr,
   output logic col_valid,
   output logic col_write,
   output logic dq_oe,
   output logic read_data_valid,
   output logic [12:0] operating_mode_settings
);
   import sdmi_pkg::*;

   // only the three documented page sizes have a wrap point the sequencer can serve
   if (PAGE_COLS != int'(PAGE_X16) && PAGE_COLS != int'(PAGE_X8)
       && PAGE_COLS != int'(PAGE_X4)) begin
      $error("unsupported page size");
   end

   // ==========================================
   // reset release and pin synchronisers
   logic [1:0] rst_sync_r;
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rst_sync_r <= 2'h0;
      end else begin
         rst_sync_r <= {rst_sync_r[0], 1'b1};
      end
   end
   wire rst_n = rst_sync_r[1];

   logic [19:0] pin_s1_r, pin_s2_r;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pin_s1_r <= 20'h0007f;
         pin_s2_r <= 20'h0007f;
      end else begin
         pin_s1_r <= {addr, bank_select_high, bank_select_low, cke, cs_n, ras_n, cas_n, we_n};
         pin_s2_r <= pin_s1_r;
      end
   end
   wire [12:0] a_s = pin_s2_r[19:7];
   wire bs_hi = pin_s2_r[6];
   wire bs_lo = pin_s2_r[5];
   wire cke_s = pin_s2_r[4];
   wire [3:0] cmd = pin_s2_r[3:0];

   // ==========================================
   // state
   typedef struct packed {
      sdmi_state_t st;
      logic [12:0] mode;
      logic [10:0] start;
      logic [10:0] cnt;
      logic wr;
      logic [2:0] lat_pipe;
      logic oe;
      logic rdv;
      logic [10:0] col;
      logic cv;
      logic cke_prev;
   } sdmi_regs_t;

   sdmi_regs_t q_r, q_nxt;

   logic [10:0] len;
   logic [10:0] mask;
   logic [10:0] off;
   logic [1:0] lat;
   always_comb begin
      case (q_r.mode[BURST_LSB +: 3])
         BURST_2: len = 11'h002;
         BURST_4: len = 11'h004;
         BURST_8: len = 11'h008;
         BURST_PAGE: len = 11'(PAGE_COLS);
         default: len = 11'h001;
      endcase
      mask = len - 11'h001;
      // reserved codes fall back to three
      lat = (q_r.mode[LAT_LSB +: 3] == LAT_2) ? 2'h2 : 2'h3;
      if (q_r.mode[ORDER_BIT] && q_r.mode[BURST_LSB +: 3] != BURST_PAGE) begin
         off = (q_r.start ^ q_r.cnt) & mask;
      end else begin
         off = (q_r.start + q_r.cnt) & mask;
      end
   end

   wire cmd_ok = cke_s & q_r.cke_prev;
   wire [10:0] wlen = q_r.mode[WBURST_BIT] ? 11'h001 : len;

   always_comb begin
      q_nxt = q_r;
      q_nxt.cke_prev = cke_s;
      q_nxt.cv = 1'b0;
      q_nxt.lat_pipe = {q_r.lat_pipe[1:0], 1'b0};
      if (cmd_ok && cmd == CMD_MODE_LOAD && !bs_hi && !bs_lo) begin
         q_nxt.mode = a_s;
         q_nxt.st = SDMI_IDLE;
         q_nxt.oe = 1'b0;
         q_nxt.rdv = 1'b0;
         q_nxt.lat_pipe = 3'h0;
      end else if (cmd_ok && (cmd == CMD_READ || cmd == CMD_WRITE)) begin
         q_nxt.st = SDMI_BURST;
         // bits above the page (auto-precharge flag) must not steer the column
         q_nxt.start = a_s[10:0] & 11'(PAGE_COLS - 1);
         q_nxt.cnt = 11'h000;
         q_nxt.wr = (cmd == CMD_WRITE);
      end else if (cmd_ok && cmd == CMD_TERM) begin
         q_nxt.st = SDMI_IDLE;
      end
      case (q_r.st)
         SDMI_BURST: begin
            // upper bits hold the block, offset wraps
            q_nxt.col = (q_r.start & ~mask) | off;
            q_nxt.cv = 1'b1;
            if (!q_r.wr) begin
               q_nxt.lat_pipe[0] = 1'b1;
            end
            if (q_nxt.st == SDMI_BURST && q_nxt.cnt == q_r.cnt) begin
               q_nxt.cnt = q_r.cnt + 11'h001;
               if (q_r.mode[BURST_LSB +: 3] != BURST_PAGE
                   && q_r.cnt + 11'h001 >= (q_r.wr ? wlen : len)) begin
                  q_nxt.st = SDMI_IDLE;
               end
            end
         end
         SDMI_IDLE: begin
         end
         default: q_nxt.st = SDMI_IDLE;
      endcase
      // drive one edge before data valid
      if (!(cmd_ok && cmd == CMD_MODE_LOAD && !bs_hi && !bs_lo)) begin
         q_nxt.oe = (lat == 2'h2) ? q_nxt.lat_pipe[0] : q_nxt.lat_pipe[1];
         q_nxt.rdv = (lat == 2'h2) ? q_r.lat_pipe[0] : q_r.lat_pipe[1];
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         q_r <= '{st: SDMI_IDLE, mode: MODE_RESET, default: '0};
      end else begin
         q_r <= q_nxt;
      end
   end

   assign col_addr = q_r.col;
   assign col_valid = q_r.cv;
   assign col_write = q_r.wr & q_r.cv;
   assign dq_oe = q_r.oe;
   assign read_data_valid = q_r.rdv;
   assign operating_mode_settings = q_r.mode;

   // ==========================================
   // checks
   sequence load_seq;
      cmd_ok && cmd == CMD_MODE_LOAD && !bs_hi && !bs_lo;
   endsequence
   // reads started from an empty pipe, so the latency count is clean
   sequence read2_seq;
      cmd_ok && cmd == CMD_READ && q_r.st == SDMI_IDLE && q_r.lat_pipe == 3'h0 && lat == 2'h2;
   endsequence
   sequence read3_seq;
      cmd_ok && cmd == CMD_READ && q_r.st == SDMI_IDLE && q_r.lat_pipe == 3'h0 && lat == 2'h3;
   endsequence
   sequence drive_valid_seq;
      dq_oe ##1 read_data_valid;
   endsequence
   mode_capture_a: assert property (@(posedge clk) disable iff (!rst_n)
      load_seq |=> operating_mode_settings == $past(a_s))
      else $error("mode not captured");
   float_after_load_a: assert property (@(posedge clk) disable iff (!rst_n)
      load_seq |=> !dq_oe)
      else $error("outputs driven after mode load");
   oe_before_valid_a: assert property (@(posedge clk) disable iff (!rst_n)
      $rose(read_data_valid) |-> $past(dq_oe))
      else $error("data valid without drive");
   col_in_block_a: assert property (@(posedge clk) disable iff (!rst_n)
      col_valid && q_r.mode[2:0] != BURST_PAGE |-> ((col_addr ^ q_r.start) & ~mask) == 0)
      else $error("column left burst block");
   single_write_a: assert property (@(posedge clk) disable iff (!rst_n)
      col_write && q_r.mode[WBURST_BIT] |=> !col_write)
      else $error("write burst despite single mode");
   burst_one_a: assert property (@(posedge clk) disable iff (!rst_n)
      col_valid && q_r.mode[2:0] == BURST_1 |-> col_addr == q_r.start)
      else $error("burst of one column wrong");
   page_limit_a: assert property (@(posedge clk) disable iff (!rst_n)
      col_valid |-> int'(col_addr) < PAGE_COLS)
      else $error("column beyond page");
   read_lat2_a: assert property (@(posedge clk) disable iff (!rst_n)
      read2_seq |=> !dq_oe ##1 drive_valid_seq)
      else $error("latency two timing wrong");
   read_lat3_a: assert property (@(posedge clk) disable iff (!rst_n)
      read3_seq |=> !dq_oe ##1 !dq_oe ##1 drive_valid_seq)
      else $error("latency three timing wrong");
endmodule

// file: sim/sdmi_ctrl_model.sv
`timescale 1ns/10ps
module sdmi_ctrl_model
   import sdmi_pkg::*;
#(
   parameter int WAIT_POWER = 4000,
   parameter int WAIT_PRE = 2,
   parameter int WAIT_REF = 3,
   parameter int WAIT_MODE = 2
) (
   // clock
   input wire logic clk,
   // command pins
   output logic cke,
   output logic cs_n,
   output logic ras_n,
   output logic cas_n,
   output logic we_n,
   output logic bank_select_low,
   output logic bank_select_high,
   output logic [12:0] addr
);
   logic [3:0] cmd;
   assign {cs_n, ras_n, cas_n, we_n} = cmd;
   initial begin
      cke = 1'b0;
      cmd = CMD_NOP;
      bank_select_low = 1'b0;
      bank_select_high = 1'b0;
      addr = 13'h0;
   end
   // ==========================================
   // bus moves every idle cycle, so stale values never help the device
   task automatic idle(input int n);
      repeat (n) begin
         @(negedge clk);
         addr = ~addr;
         cmd[3] = ~cmd[3]; // no-operation and deselect alternate
      end
   endtask
   task automatic issue_bank(input logic [3:0] c, input logic [1:0] b, input logic [12:0] a);
      @(negedge clk);
      cmd = c;
      {bank_select_high, bank_select_low} = b;
      addr = a;
      @(negedge clk);
      cmd = CMD_NOP;
      {bank_select_high, bank_select_low} = ~b;
      addr = ~a;
   endtask
   task automatic issue(input logic [3:0] c, input logic bh, input logic [12:0] a);
      issue_bank(c, {bh, 1'b0}, a);
   endtask
   task automatic load_mode(input logic [12:0] m);
      issue(CMD_MODE_LOAD, 1'b0, m);
      idle(WAIT_MODE);
   endtask
   task automatic power_up(input logic [12:0] m, input logic late_ref);
      cke = 1'b0;
      idle(WAIT_POWER / 2);
      cke = 1'b1;
      idle(WAIT_POWER / 2);
      issue(4'h2, 1'b0, 13'h0400);
      idle(WAIT_PRE);
      if (late_ref) begin
         load_mode(m);
      end
      repeat (2) begin
         issue(4'h1, 1'b0, 13'h0);
         idle(WAIT_REF);
      end
      if (!late_ref) begin
         load_mode(m);
      end
   endtask
endmodule

// file: sim/sdram_init_and_mode_setup_test.sv
`timescale 1ns/10ps
module sdram_init_and_mode_setup_test;
   import sdmi_pkg::*;
   logic clk = 1'b0;
   logic resetn = 1'b0;
   logic cke, cs_n, ras_n, cas_n, we_n, bank_select_low, bank_select_high;
   logic [12:0] addr, operating_mode_settings;
   logic [10:0] col_addr;
   logic col_valid, col_write, dq_oe, read_data_valid;
   int err_total = 0;
   int total_checks = 0;
   always #12.5 clk = ~clk;
   sdmi_ctrl_model ctl (.clk(clk), .cke(cke), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n),
      .we_n(we_n), .bank_select_low(bank_select_low), .bank_select_high(bank_select_high),
      .addr(addr));
   sdmi_core #(.PAGE_COLS(512)) dut (.clk(clk), .resetn(resetn), .cke(cke), .cs_n(cs_n),
      .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .bank_select_low(bank_select_low),
      .bank_select_high(bank_select_high), .addr(addr), .col_addr(col_addr),
      .col_valid(col_valid), .col_write(col_write), .dq_oe(dq_oe),
      .read_data_valid(read_data_valid), .operating_mode_settings(operating_mode_settings));
   // ==========================================
   // helpers
   function automatic logic [12:0] mk(input logic wb, input logic [2:0] lat, input logic o,
      input logic [2:0] bl);
      return {3'h0, wb, 2'h0, lat, o, bl};
   endfunction
   task automatic chk(input string s, input logic [12:0] e, input logic [12:0] g);
      total_checks++;
      if (g !== e) begin
         $display("BAD %s expected %h seen %h", s, e, g);
         err_total++;
      end
   endtask
   task automatic end_sim();
      $display("checks %0d mismatches %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   task automatic beat();
      int w;
      w = 0;
      while (col_valid !== 1'b1) begin
         @(negedge clk);
         w++;
         if (w > 20) begin
            $display("BAD col_valid expected 1 seen timeout");
            err_total++;
            end_sim();
         end
      end
   endtask
   task automatic burst(input logic [12:0] m, input logic [10:0] st, input int n, input int nb);
      logic [10:0] lm, e;
      ctl.idle(4);
      ctl.issue(CMD_MODE_LOAD, 1'b0, m);
      ctl.idle(4);
      chk("mode", m, operating_mode_settings);
      ctl.issue(CMD_READ, 1'b0, {2'h0, st});
      beat();
      lm = 11'(n - 1);
      for (int k = 0; k < nb; k++) begin
         e = m[ORDER_BIT] ? (st ^ 11'(k)) : (st + 11'(k));
         e = (st & ~lm) | (e & lm);
         chk("col", {2'h0, e}, {2'h0, col_addr});
         if (k < 2) begin
            chk("dq_oe", {12'h0, k == 1 || m[6:4] == LAT_2}, {12'h0, dq_oe});
            chk("rdv", {12'h0, k == 1 && m[6:4] == LAT_2}, {12'h0, read_data_valid});
         end
         @(negedge clk);
      end
      if (nb < n) begin
         ctl.issue(CMD_TERM, 1'b0, 13'h0);
         ctl.idle(4);
      end
      chk("col_valid", 13'h0, {12'h0, col_valid});
   endtask
   // ==========================================
   // scenarios
   task automatic t_init();
      ctl.power_up(mk(1'b0, LAT_2, 1'b0, BURST_4), 1'b0);
      ctl.idle(2);
      chk("mode", mk(1'b0, LAT_2, 1'b0, BURST_4), operating_mode_settings);
      chk("dq_oe", 13'h0, {12'h0, dq_oe});
      $display("init test done");
   endtask
   task automatic t_refuse();
      ctl.issue(CMD_MODE_LOAD, 1'b1, mk(1'b0, LAT_3, 1'b1, BURST_8));
      ctl.idle(4);
      chk("mode", mk(1'b0, LAT_2, 1'b0, BURST_4), operating_mode_settings);
      ctl.issue_bank(CMD_MODE_LOAD, 2'h1, mk(1'b1, LAT_3, 1'b0, BURST_2));
      ctl.idle(4);
      chk("mode", mk(1'b0, LAT_2, 1'b0, BURST_4), operating_mode_settings);
      $display("refuse test done");
   endtask
   task automatic t_bursts();
      burst(mk(1'b0, LAT_2, 1'b0, BURST_2), 11'h001, 2, 2);
      burst(mk(1'b0, LAT_3, 1'b0, BURST_4), 11'h013, 4, 4);
      burst(mk(1'b0, LAT_2, 1'b1, BURST_8), 11'h029, 8, 8);
      burst(mk(1'b0, LAT_3, 1'b1, BURST_4), 11'h05d, 4, 4);
      burst(mk(1'b0, LAT_3, 1'b1, BURST_1), 11'h1f5, 1, 1);
      burst(mk(1'b0, LAT_3, 1'b0, BURST_PAGE), 11'h1fe, 512, 4);
      $display("burst test done");
   endtask
   task automatic t_write();
      ctl.issue(CMD_MODE_LOAD, 1'b0, mk(1'b1, LAT_2, 1'b0, BURST_4));
      ctl.idle(4);
      ctl.issue(CMD_WRITE, 1'b0, 13'h0042);
      beat();
      chk("col_write", 13'h1, {12'h0, col_write});
      chk("col", 13'h042, {2'h0, col_addr});
      @(negedge clk);
      chk("col_valid", 13'h0, {12'h0, col_valid});
      ctl.issue(CMD_MODE_LOAD, 1'b0, mk(1'b0, LAT_2, 1'b0, BURST_4));
      ctl.idle(4);
      ctl.issue(CMD_WRITE, 1'b0, 13'h0042);
      beat();
      for (int k = 0; k < 4; k++) begin
         chk("col_write", 13'h1, {12'h0, col_write});
         chk("col", {11'h0, 2'(k + 2)} | 13'h040, {2'h0, col_addr});
         chk("dq_oe", 13'h0, {12'h0, dq_oe});
         @(negedge clk);
      end
      chk("col_valid", 13'h0, {12'h0, col_valid});
      $display("write test done");
   endtask
   task automatic t_reinit();
      @(negedge clk);
      resetn = 1'b0;
      repeat (3) @(negedge clk);
      chk("mode", MODE_RESET, operating_mode_settings);
      chk("col_valid", 13'h0, {12'h0, col_valid});
      resetn = 1'b1;
      ctl.power_up(mk(1'b0, LAT_3, 1'b1, BURST_8), 1'b1);
      ctl.idle(2);
      chk("mode", mk(1'b0, LAT_3, 1'b1, BURST_8), operating_mode_settings);
      $display("reinit test done");
   endtask
   initial begin
      repeat (3) @(negedge clk);
      resetn = 1'b1;
      t_init();
      t_refuse();
      t_bursts();
      t_write();
      t_reinit();
      end_sim();
   end
endmodule
